// >>> hw/slc_device.sv
// Servo end of the command layer: frame reception, decoding, phases, replies.
// Assumes the master keeps its own sequencing and drives the link on clk.
`timescale 1ns/100ps

// Summary of operation
// [RULE1] Main command alone is a full frame
// [RULE2] Control byte fixed; only information bytes used
// [RULE3] Bytes 1 to 16 carry the main command
// [RULE4] Subcommand held in bytes 17 to 29
// [RULE5] First phase waits idle for connection
// [RULE6] Second phase allows asynchronous commands only
// [RULE7] Third phase accepts both command classes
// [RULE8] Communications cycle is whole transmission-cycle multiple
// [RULE9] Reply returns in the following cycle
// [RULE10] Liveness counter refreshed and checked each cycle
// [RULE11] Lockstep commands valid only in phase three
// [RULE12] Master waits completion before next asynchronous command
// [RULE13] No liveness check on asynchronous commands
// [RULE14] Decode idle, parameter read, parameter write
// [RULE15] Decode persistent parameter save
// [RULE16] Decode settings apply
// [RULE17] Decode identity read
// [RULE18] Decode fault read and fault clear
// [RULE19] Decode link open, release, lockstep start
// [RULE20] Decode holding lock apply, release, coordinates
// [RULE21] Open, start and release move the phase
// [RULE22] Unknown or phase-illegal codes answered with error
module slc_device #(
  // Identity value is arbitrary.
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the master
  slc_link_if.dev link,
  // Servo data sources
  input wire logic [7:0] param_rdata,
  input wire logic [7:0] fault_code,
  // Servo controls
  output slc_pkg::slc_phase_e phase,
  output logic brake_release,
  output logic param_rd,
  output logic param_wr,
  output logic [7:0] param_addr,
  output logic [7:0] param_wdata,
  output logic param_save,
  output logic settings_apply,
  output logic fault_clear,
  output logic coord_set,
  output logic liveness_fault
);
  import slc_pkg::*;

  // ------------------------------------------------------------
  // Frame reception
  // ------------------------------------------------------------
  logic [4:0] rx_idx;
  logic [4:0] cur_idx;
  logic ctl_ok;
  logic [7:0] main_code;
  logic [7:0] main_arg;
  logic [7:0] main_data;
  logic [7:0] live_in;
  logic [7:0] last_live;
  logic [7:0] sub_code;
  logic frame_end;

  assign cur_idx = link.cmd_sof ? IDX_CTL : rx_idx;
  assign frame_end = link.cmd_valid && (cur_idx == FRAME_LAST_IDX) && ctl_ok;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_idx <= 5'h00;
    end else if (link.cmd_valid) begin
      rx_idx <= cur_idx + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_ok <= 1'b0;
      main_code <= 8'h00;
      main_arg <= 8'h00;
      main_data <= 8'h00;
      live_in <= 8'h00;
      sub_code <= 8'h00;
    end else if (link.cmd_valid) begin
      unique case (cur_idx)
        IDX_CTL: ctl_ok <= (link.cmd_data == CMD_CTL); // RULE2
        IDX_CODE: main_code <= link.cmd_data; // RULE3
        IDX_ARG: main_arg <= link.cmd_data;
        IDX_DATA: main_data <= link.cmd_data;
        IDX_LIVE: live_in <= link.cmd_data;
        IDX_SUB: sub_code <= link.cmd_data; // RULE4
        default: ;
      endcase
    end
  end

  // Every received frame moves the reference, so gaps of asynchronous traffic
  // between lockstep frames do not raise false liveness faults.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_live <= 8'h00;
    end else if (frame_end) begin
      last_live <= live_in;
    end
  end

  // ------------------------------------------------------------
  // Decoding and phase
  // ------------------------------------------------------------
  slc_phase_e state;
  slc_phase_e next_phase;
  logic sync_cls;
  logic accept;
  logic respond;
  logic execute;
  logic wdt_bad;
  logic [7:0] next_stat;
  logic [7:0] next_data;

  always_comb begin
    sync_cls = slc_is_sync(main_code);
    accept = slc_is_known(main_code) && !(sync_cls && state != LOCKSTEP_PHASE); // RULE11
    respond = (state != AWAITING_LINK_PHASE) || (main_code == LINK_OPEN_CMD); // RULE5
    execute = frame_end && respond && accept; // RULE22
    wdt_bad = (state == LOCKSTEP_PHASE) && sync_cls &&
              (live_in != 8'(last_live + 8'h01)); // RULE10 RULE13
  end

  always_comb begin
    next_phase = state;
    unique case (state)
      AWAITING_LINK_PHASE: begin
        if (execute && main_code == LINK_OPEN_CMD) begin
          next_phase = ASYNC_ONLY_PHASE; // RULE21
        end
      end
      ASYNC_ONLY_PHASE: begin
        if (execute && main_code == LOCKSTEP_START_CMD) begin
          next_phase = LOCKSTEP_PHASE; // RULE21
        end else if (execute && main_code == LINK_RELEASE_CMD) begin
          next_phase = AWAITING_LINK_PHASE; // RULE21
        end
      end
      LOCKSTEP_PHASE: begin
        if (execute && main_code == LINK_RELEASE_CMD) begin
          next_phase = AWAITING_LINK_PHASE; // RULE7 RULE21
        end
      end
      default: next_phase = AWAITING_LINK_PHASE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= AWAITING_LINK_PHASE;
    end else begin
      state <= next_phase; // RULE19
    end
  end

  assign phase = state;

  always_comb begin
    next_stat = 8'h00;
    next_stat[ST_DONE_BIT] = 1'b1;
    next_stat[ST_ERR_BIT] = !accept; // RULE22 RULE6
    next_stat[ST_WDT_BIT] = wdt_bad;
    next_stat[ST_SUB_BIT] = !slc_sub_ok(sub_code); // RULE1
    next_stat[ST_PH_LSB +: 2] = next_phase;
    next_data = 8'h00;
    if (accept) begin
      if (main_code == PARAM_READ_CMD) begin
        next_data = param_rdata; // RULE14
      end else if (main_code == IDENTITY_READ_CMD) begin
        next_data = ID_CODE; // RULE17
      end else if (main_code == FAULT_READ_CMD) begin
        next_data = fault_code; // RULE18
      end
    end
  end

  // ------------------------------------------------------------
  // Servo side actions
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      param_rd <= 1'b0;
      param_wr <= 1'b0;
      param_save <= 1'b0;
      settings_apply <= 1'b0;
      fault_clear <= 1'b0;
      coord_set <= 1'b0;
    end else begin
      param_rd <= execute && (main_code == PARAM_READ_CMD); // RULE14
      param_wr <= execute && (main_code == PARAM_WRITE_CMD); // RULE14
      param_save <= execute && (main_code == PERSISTENT_PARAM_SAVE_CMD); // RULE15
      settings_apply <= execute && (main_code == SETTINGS_APPLY_CMD); // RULE16
      fault_clear <= execute && (main_code == FAULT_CLEAR_CMD); // RULE18
      coord_set <= execute && (main_code == COORD_SET_CMD); // RULE20
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      param_addr <= 8'h00;
      param_wdata <= 8'h00;
    end else if (execute && (main_code == PARAM_READ_CMD || main_code == PARAM_WRITE_CMD)) begin
      param_addr <= main_arg;
      param_wdata <= main_data;
    end
  end

  // The brake stays engaged from reset until the master releases it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brake_release <= 1'b0;
    end else if (execute && main_code == HOLDING_LOCK_APPLY_CMD) begin
      brake_release <= 1'b0; // RULE20
    end else if (execute && main_code == HOLDING_LOCK_RELEASE_CMD) begin
      brake_release <= 1'b1; // RULE20
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      liveness_fault <= 1'b0;
    end else begin
      liveness_fault <= frame_end && respond && wdt_bad; // RULE10
    end
  end

  // ------------------------------------------------------------
  // Reply
  // ------------------------------------------------------------
  logic rsp_pend;
  logic [7:0] rsp_code;
  logic [7:0] rsp_stat;
  logic [7:0] rsp_dat;
  logic [7:0] rsp_echo;
  logic [7:0] rsp_sub;
  logic tx_active;
  logic [4:0] tx_idx;
  logic launch;
  logic [7:0] tx_code;
  logic [7:0] tx_stat;
  logic [7:0] tx_dat;
  logic [7:0] tx_echo;
  logic [7:0] tx_sub;
  logic [7:0] dev_live;
  logic [7:0] tx_byte;

  // The reply waits for the next cycle mark, so it lands in the following cycle.
  assign launch = link.cyc_start && rsp_pend && !tx_active; // RULE9

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_pend <= 1'b0;
      rsp_code <= 8'h00;
      rsp_stat <= 8'h00;
      rsp_dat <= 8'h00;
      rsp_echo <= 8'h00;
      rsp_sub <= 8'h00;
    end else if (frame_end && respond) begin
      rsp_pend <= 1'b1;
      rsp_code <= main_code;
      rsp_stat <= next_stat;
      rsp_dat <= next_data;
      rsp_echo <= live_in;
      rsp_sub <= sub_code;
    end else if (launch) begin
      rsp_pend <= 1'b0;
    end
  end

  // A shadow copy keeps a reply steady if a new frame ends while it is sent.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_code <= 8'h00;
      tx_stat <= 8'h00;
      tx_dat <= 8'h00;
      tx_echo <= 8'h00;
      tx_sub <= 8'h00;
      dev_live <= 8'h00;
    end else if (launch) begin
      tx_code <= rsp_code;
      tx_stat <= rsp_stat;
      tx_dat <= rsp_dat;
      tx_echo <= rsp_echo;
      tx_sub <= rsp_sub;
      dev_live <= dev_live + 8'h01; // RULE10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_active <= 1'b0;
      tx_idx <= 5'h00;
    end else if (launch) begin
      tx_active <= 1'b1;
      tx_idx <= 5'h00;
    end else if (tx_active) begin
      tx_active <= (tx_idx != FRAME_LAST_IDX);
      tx_idx <= tx_idx + 5'h01;
    end
  end

  always_comb begin
    unique case (tx_idx)
      IDX_CTL: tx_byte = RSP_CTL; // RULE2
      IDX_CODE: tx_byte = tx_code;
      IDX_ARG: tx_byte = tx_stat;
      IDX_DATA: tx_byte = tx_dat;
      IDX_ECHO: tx_byte = tx_echo;
      IDX_LIVE: tx_byte = dev_live;
      IDX_SUB: tx_byte = tx_sub; // RULE4
      default: tx_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.rsp_valid <= 1'b0;
      link.rsp_sof <= 1'b0;
      link.rsp_data <= 8'h00;
    end else begin
      link.rsp_valid <= tx_active;
      link.rsp_sof <= tx_active && (tx_idx == IDX_CTL);
      link.rsp_data <= tx_active ? tx_byte : 8'h00;
    end
  end

endmodule : slc_device

// >>> hw/slc_host.sv
// Master end of the command layer: cycle timing, command frames, reply capture.
// Assumes the servo end replies in the cycle after each frame.
`timescale 1ns/100ps
module slc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the servo
  slc_link_if.host link,
  // Command request
  input wire logic req,
  input wire logic [7:0] req_code,
  input wire logic [7:0] req_arg,
  input wire logic [7:0] req_data,
  input wire logic [7:0] req_sub,
  output logic ready,
  output logic reject,
  // Reply
  output logic rsp_strobe,
  output logic [7:0] rsp_code,
  output logic [7:0] rsp_status,
  output logic [7:0] rsp_data,
  output logic [1:0] link_phase,
  output logic link_fault
);
  import slc_pkg::*;

  // ------------------------------------------------------------
  // Cycle timing
  // ------------------------------------------------------------
  logic [5:0] div_cnt;
  logic [2:0] comm_cnt;
  logic tx_tick;
  logic comm_tick;

  assign tx_tick = (div_cnt == TX_DIV_LAST);
  assign comm_tick = tx_tick && (comm_cnt == COMM_LAST); // RULE8

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 6'h00;
      comm_cnt <= 3'h0;
    end else begin
      div_cnt <= tx_tick ? 6'h00 : div_cnt + 6'h01;
      if (tx_tick) begin
        comm_cnt <= (comm_cnt == COMM_LAST) ? 3'h0 : comm_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.cyc_start <= 1'b0;
    end else begin
      link.cyc_start <= comm_tick;
    end
  end

  // ------------------------------------------------------------
  // Requests and frame start
  // ------------------------------------------------------------
  logic pend;
  logic [7:0] p_code;
  logic [7:0] p_arg;
  logic [7:0] p_data;
  logic [7:0] p_sub;
  logic async_wait;
  logic [7:0] wait_live;
  logic [7:0] live;
  logic tx_active;
  logic [4:0] tx_idx;
  logic send_user;
  logic start;
  logic take;
  logic rx_done;
  logic [7:0] rx_echo;
  logic [7:0] f_code;
  logic [7:0] f_arg;
  logic [7:0] f_data;
  logic [7:0] f_sub;

  assign take = req && ready;
  assign send_user = pend && !async_wait; // RULE12
  // Idle frames keep the lockstep beat alive between requests.
  assign start = comm_tick && !tx_active && (send_user || link_phase == LOCKSTEP_PHASE); // RULE9

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      reject <= 1'b0;
      p_code <= 8'h00;
      p_arg <= 8'h00;
      p_data <= 8'h00;
      p_sub <= 8'h00;
    end else begin
      reject <= take && slc_is_sync(req_code) && (link_phase != LOCKSTEP_PHASE); // RULE6
      if (take && !(slc_is_sync(req_code) && link_phase != LOCKSTEP_PHASE)) begin
        pend <= 1'b1;
        p_code <= req_code;
        p_arg <= req_arg;
        p_data <= req_data;
        p_sub <= req_sub;
      end else if (start && send_user) begin
        pend <= 1'b0;
      end
    end
  end

  // A new wait wins over the end of an older reply in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      async_wait <= 1'b0;
      wait_live <= 8'h00;
    end else if (start && send_user && !slc_is_sync(p_code)) begin
      async_wait <= 1'b1; // RULE12
      wait_live <= live;
    end else if (rx_done && rx_echo == wait_live) begin
      async_wait <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= !pend && !async_wait && !take && !(start && send_user);
    end
  end

  // ------------------------------------------------------------
  // Frame transmission
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_active <= 1'b0;
      tx_idx <= FRAME_LAST_IDX + 5'h01;
      live <= 8'h00;
      f_code <= 8'h00;
      f_arg <= 8'h00;
      f_data <= 8'h00;
      f_sub <= 8'h00;
    end else if (start) begin
      tx_active <= 1'b1;
      tx_idx <= 5'h00;
      live <= live + 8'h01; // RULE10
      f_code <= send_user ? p_code : IDLE_COMMAND; // RULE1
      f_arg <= send_user ? p_arg : 8'h00;
      f_data <= send_user ? p_data : 8'h00;
      f_sub <= send_user ? p_sub : 8'h00;
    end else if (tx_active) begin
      tx_active <= (tx_idx != FRAME_LAST_IDX);
      tx_idx <= tx_idx + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.cmd_valid <= 1'b0;
      link.cmd_sof <= 1'b0;
      link.cmd_data <= 8'h00;
    end else begin
      link.cmd_valid <= tx_active;
      link.cmd_sof <= tx_active && (tx_idx == IDX_CTL);
      unique case (tx_idx)
        IDX_CTL: link.cmd_data <= CMD_CTL; // RULE2
        IDX_CODE: link.cmd_data <= f_code; // RULE3
        IDX_ARG: link.cmd_data <= f_arg;
        IDX_DATA: link.cmd_data <= f_data;
        IDX_LIVE: link.cmd_data <= live - 8'h01;
        IDX_SUB: link.cmd_data <= f_sub; // RULE4
        default: link.cmd_data <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Reply capture
  // ------------------------------------------------------------
  logic [4:0] rx_idx;
  logic [4:0] cur_idx;
  logic ctl_ok;
  logic [7:0] r_code;
  logic [7:0] r_stat;
  logic [7:0] r_data;
  logic [7:0] r_live;
  logic [7:0] last_dev;

  assign cur_idx = link.rsp_sof ? IDX_CTL : rx_idx;
  assign rx_done = link.rsp_valid && (cur_idx == FRAME_LAST_IDX) && ctl_ok;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_idx <= 5'h00;
      ctl_ok <= 1'b0;
      r_code <= 8'h00;
      r_stat <= 8'h00;
      r_data <= 8'h00;
      rx_echo <= 8'h00;
      r_live <= 8'h00;
    end else if (link.rsp_valid) begin
      rx_idx <= cur_idx + 5'h01;
      unique case (cur_idx)
        IDX_CTL: ctl_ok <= (link.rsp_data == RSP_CTL); // RULE2
        IDX_CODE: r_code <= link.rsp_data;
        IDX_ARG: r_stat <= link.rsp_data;
        IDX_DATA: r_data <= link.rsp_data;
        IDX_ECHO: rx_echo <= link.rsp_data;
        IDX_LIVE: r_live <= link.rsp_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_strobe <= 1'b0;
      rsp_code <= 8'h00;
      rsp_status <= 8'h00;
      rsp_data <= 8'h00;
      link_phase <= AWAITING_LINK_PHASE;
      link_fault <= 1'b0;
      last_dev <= 8'h00;
    end else begin
      rsp_strobe <= rx_done;
      link_fault <= rx_done && (link_phase == LOCKSTEP_PHASE) && slc_is_sync(r_code) &&
                    (r_live != 8'(last_dev + 8'h01)); // RULE10
      if (rx_done) begin
        rsp_code <= r_code;
        rsp_status <= r_stat;
        rsp_data <= r_data;
        link_phase <= r_stat[ST_PH_LSB +: 2];
        last_dev <= r_live;
      end
    end
  end

endmodule : slc_host

// >>> inc/slc_link_if.sv
// Byte-serial frame link between the master end and the servo end.
// Assumes both ends share clk; no crossing is needed.
`timescale 1ns/100ps
interface slc_link_if;
  logic cyc_start;
  logic cmd_valid;
  logic cmd_sof;
  logic [7:0] cmd_data;
  logic rsp_valid;
  logic rsp_sof;
  logic [7:0] rsp_data;

  modport dev (
    input cyc_start,
    input cmd_valid,
    input cmd_sof,
    input cmd_data,
    output rsp_valid,
    output rsp_sof,
    output rsp_data
  );

  modport host (
    output cyc_start,
    output cmd_valid,
    output cmd_sof,
    output cmd_data,
    input rsp_valid,
    input rsp_sof,
    input rsp_data
  );
endinterface : slc_link_if

// >>> inc/slc_pkg.sv
// Shared constants, codes and helpers of the servo link command layer.
// Assumes both ends run on one 25 MHz clock and meet in slc_link_if.
package slc_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int TX_CYCLE_NS = 2000;
  localparam int TX_CYCLE_CLKS = (TX_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] TX_DIV_LAST = 6'(TX_CYCLE_CLKS - 1);
  localparam int COMM_MULT = 2;
  localparam logic [2:0] COMM_LAST = 3'(COMM_MULT - 1);

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam logic [4:0] IDX_CTL = 5'h00;
  localparam logic [4:0] IDX_CODE = 5'h01;
  localparam logic [4:0] IDX_ARG = 5'h02;
  localparam logic [4:0] IDX_DATA = 5'h03;
  localparam logic [4:0] IDX_ECHO = 5'h0F;
  localparam logic [4:0] IDX_LIVE = 5'h10;
  localparam logic [4:0] IDX_SUB = 5'h11;
  localparam logic [4:0] FRAME_LAST_IDX = 5'h1D;
  localparam logic [7:0] CMD_CTL = 8'h03;
  localparam logic [7:0] RSP_CTL = 8'h01;

  // ------------------------------------------------------------
  // Response status byte
  // ------------------------------------------------------------
  localparam int ST_ERR_BIT = 0;
  localparam int ST_WDT_BIT = 1;
  localparam int ST_SUB_BIT = 2;
  localparam int ST_PH_LSB = 4;
  localparam int ST_DONE_BIT = 7;

  // ------------------------------------------------------------
  // Phases and command codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    AWAITING_LINK_PHASE = 2'h1,
    ASYNC_ONLY_PHASE = 2'h2,
    LOCKSTEP_PHASE = 2'h3
  } slc_phase_e;

  localparam logic [7:0] IDLE_COMMAND = 8'h00;
  localparam logic [7:0] PARAM_READ_CMD = 8'h01;
  localparam logic [7:0] PARAM_WRITE_CMD = 8'h02;
  localparam logic [7:0] IDENTITY_READ_CMD = 8'h03;
  localparam logic [7:0] SETTINGS_APPLY_CMD = 8'h04;
  localparam logic [7:0] FAULT_READ_CMD = 8'h05;
  localparam logic [7:0] FAULT_CLEAR_CMD = 8'h06;
  localparam logic [7:0] LOCKSTEP_START_CMD = 8'h0D;
  localparam logic [7:0] LINK_OPEN_CMD = 8'h0E;
  localparam logic [7:0] LINK_RELEASE_CMD = 8'h0F;
  localparam logic [7:0] PERSISTENT_PARAM_SAVE_CMD = 8'h1C;
  localparam logic [7:0] COORD_SET_CMD = 8'h20;
  localparam logic [7:0] HOLDING_LOCK_APPLY_CMD = 8'h21;
  localparam logic [7:0] HOLDING_LOCK_RELEASE_CMD = 8'h22;

  function automatic logic slc_is_known(input logic [7:0] code);
    case (code)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06: return 1'b1;
      8'h0D, 8'h0E, 8'h0F, 8'h1C, 8'h20, 8'h21, 8'h22: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : slc_is_known

  // Only the coordinate and holding lock commands are treated as lockstep class.
  function automatic logic slc_is_sync(input logic [7:0] code);
    return (code == COORD_SET_CMD) || (code == HOLDING_LOCK_APPLY_CMD) ||
           (code == HOLDING_LOCK_RELEASE_CMD);
  endfunction : slc_is_sync

  function automatic logic slc_sub_ok(input logic [7:0] code);
    return (code == IDLE_COMMAND) || (code == PARAM_READ_CMD) ||
           (code == PARAM_WRITE_CMD) || (code == FAULT_READ_CMD) ||
           (code == PERSISTENT_PARAM_SAVE_CMD);
  endfunction : slc_sub_ok

endpackage : slc_pkg

// >>> testbench/servo_link_command_layer_tb_top.sv
// Bench joining the master end and the servo end over slc_link_if.
// Assumes the package, interface, both ends and the monitor are compiled.
`timescale 1ns/100ps
module servo_link_command_layer_tb_top;
  import slc_pkg::*;
  typedef struct {logic [7:0] c; logic [7:0] s; logic [7:0] d; logic k; logic [1:0] p;} slc_note_s;
  logic clk, rst, req, ready, reject, rsp_strobe, link_fault, brake_release, param_rd;
  logic param_wr, param_save, settings_apply, fault_clear, coord_set, liveness_fault;
  logic [7:0] req_code, req_arg, req_data, req_sub, param_rdata, fault_code, rsp_code;
  logic [7:0] rsp_status, rsp_data, param_addr, param_wdata, e_addr, e_wdata;
  logic [1:0] link_phase;
  logic [1:0] cur;
  logic [8:0] pl;
  logic [31:0] seed;
  slc_phase_e phase;
  slc_note_s q[$];
  slc_note_s n;
  int n_mismatch = 0;
  int compares = 0;
  int pc[9] = '{default: 0};
  logic [7:0] cds[15] = '{8'h0E, 8'h20, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h1C, 8'h0D, 8'h22, 8'h20, 8'h21, 8'h0F};
  slc_link_if link ();
  slc_host i_slc_host (.clk, .rst, .link, .req, .req_code, .req_arg, .req_data, .req_sub,
    .ready, .reject, .rsp_strobe, .rsp_code, .rsp_status, .rsp_data, .link_phase, .link_fault);
  slc_device #(.ID_CODE(8'h3C)) i_slc_device (.clk, .rst, .link, .param_rdata, .fault_code,
    .phase, .brake_release, .param_rd, .param_wr, .param_addr, .param_wdata, .param_save,
    .settings_apply, .fault_clear, .coord_set, .liveness_fault);
  slc_link_monitor i_slc_link_monitor (.clk, .rst, .cyc_start(link.cyc_start),
    .cmd_valid(link.cmd_valid), .cmd_sof(link.cmd_sof), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_sof(link.rsp_sof), .rsp_data(link.rsp_data));
  assign pl = {reject, param_rd, param_wr, settings_apply, fault_clear, param_save, coord_set,
    liveness_fault, link_fault};
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (e !== s) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask : chk
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // --------------------
  // Driver: notes each expected reply as it asks
  // --------------------
  task automatic send(input logic [7:0] c);
    logic sy;
    logic sb;
    sy = c inside {8'h20, 8'h21, 8'h22};
    @(posedge clk);
    for (int k = 0; k < 900 && ready !== 1'b1; k++) @(posedge clk);
    seed = xs(seed);
    sb = !(seed[15:8] inside {8'h00, 8'h01, 8'h02, 8'h05, 8'h1C});
    req_code <= c;
    req_arg <= seed[7:0];
    req_sub <= seed[15:8];
    req_data <= seed[23:16];
    param_rdata <= seed[31:24];
    fault_code <= ~seed[7:0];
    if (c == 8'h02) {e_addr, e_wdata} = {seed[7:0], seed[23:16]};
    req <= 1'b1;
    // A lockstep request outside lockstep is dropped by the master, so nothing is noted.
    if (!(sy && cur != 2'h3)) begin
      cur = c == 8'h0E ? 2'h2 : c == 8'h0D ? 2'h3 : c == 8'h0F ? 2'h1 : cur;
      q.push_back('{c, {2'h2, cur, 1'b0, sb, 1'b0, c == 8'h07},
        c == 8'h01 ? seed[31:24] : c == 8'h03 ? 8'h3C : ~seed[7:0],
        c inside {8'h01, 8'h03, 8'h05}, cur});
    end
    @(posedge clk);
    req <= 1'b0;
  endtask : send
  task automatic drain;
    for (int k = 0; k < 1000 && q.size() != 0; k++) @(posedge clk);
  endtask : drain
  always @(posedge clk) begin
    foreach (pc[i]) if (pl[i] === 1'b1) pc[i]++;
    if (rsp_strobe === 1'b1 && rsp_code !== 8'h00) begin
      if (q.size() == 0) chk("reply count", 8'h00, 8'h01);
      else begin
        n = q.pop_front();
        chk("code", n.c, rsp_code);
        chk("status", n.s, rsp_status & 8'hB7);
        chk("phase", {6'h00, n.p}, {6'h00, phase});
        if (n.k) chk("data", n.d, rsp_data);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    {req_code, req_arg, req_data, req_sub, param_rdata, fault_code} = 48'h0;
    seed = 32'h0000CFFB;
    cur = 2'h1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (cds[i]) begin
      send(cds[i]);
      if (cds[i] inside {8'h21, 8'h22}) begin
        drain();
        chk("brake", {7'h00, cds[i] == 8'h22}, {7'h00, brake_release});
      end
    end
    drain();
    chk("left", 8'h00, 8'(q.size()));
    chk("param addr", e_addr, param_addr);
    chk("param wdata", e_wdata, param_wdata);
    foreach (pc[i]) chk("pulse count", {7'h00, i > 1}, pc[i][7:0]);
    close_out();
  end
endmodule : servo_link_command_layer_tb_top

// >>> testbench/slc_link_monitor.sv
// Link checker: framing and cycle alignment on slc_link_if.
// Assumes it sits beside the interface on the shared clock.
`timescale 1ns/100ps
module slc_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic cyc_start,
  input wire logic cmd_valid,
  input wire logic cmd_sof,
  input wire logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_sof,
  input wire logic [7:0] rsp_data
);
  logic [5:0] n_cmd;
  logic [5:0] n_rsp;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Byte counters keep the frame length check cheap.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_cmd <= 6'h00;
      n_rsp <= 6'h00;
    end else begin
      n_cmd <= cmd_valid ? n_cmd + 6'h01 : 6'h00;
      n_rsp <= rsp_valid ? n_rsp + 6'h01 : 6'h00;
    end
  end
  // --------------------
  // Assertions
  // --------------------
  sequence s_cmd_open;
    cmd_sof && cmd_data == 8'h03 ##1 cmd_valid && !cmd_sof;
  endsequence
  sequence s_rsp_open;
    rsp_sof && rsp_data == 8'h01 ##1 rsp_valid && !rsp_sof;
  endsequence
  a_cmd_open: assert property ($rose(cmd_valid) |-> s_cmd_open)
    else $error("command frame opens wrongly");
  a_rsp_open: assert property ($rose(rsp_valid) |-> s_rsp_open)
    else $error("reply frame opens wrongly");
  a_cmd_length: assert property ($fell(cmd_valid) |-> n_cmd == 6'h1E)
    else $error("command frame length wrong");
  a_rsp_length: assert property ($fell(rsp_valid) |-> n_rsp == 6'h1E)
    else $error("reply frame length wrong");
  a_cmd_cycle_lead: assert property (cmd_sof |-> $past(cyc_start))
    else $error("command frame not at cycle mark");
  a_rsp_cycle_lead: assert property (rsp_sof |-> $past(cyc_start, 2))
    else $error("reply frame not at cycle mark");
  a_cmd_idle_zero: assert property (!cmd_valid |-> cmd_data == 8'h00)
    else $error("command data not zero when idle");
  a_rsp_idle_zero: assert property (!rsp_valid |-> rsp_data == 8'h00)
    else $error("reply data not zero when idle");
endmodule : slc_link_monitor
